/* bench/issuer.sv */
`timescale 1ns/1ps
module issuer (
  // Clock
  input wire logic clock,
  // Instruction
  output logic cmd_valid,
  output logic [7:0] cmd_opcode,
  output logic [7:0] cmd_type,
  output logic [7:0] cmd_index,
  output logic [31:0] cmd_value
);
  initial {cmd_valid, cmd_opcode, cmd_type, cmd_index, cmd_value} = '0;
  task automatic issue(input logic [7:0] op, input logic [7:0] t, input logic [7:0] i);
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_opcode <= op;
    cmd_type <= t;
    cmd_index <= i;
    // junk value, not zero on purpose
    cmd_value <= {i, t, op, 8'hA5};
  endtask
  task automatic quiet();
    @(posedge clock);
    cmd_valid <= 1'b0;
  endtask
endmodule // issuer

/* bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic xreg_load = 1'b0;
  logic [31:0] xreg_load_value = 32'h0;
  logic cmd_valid, reply_valid, flag_equal, flag_greater, flag_less;
  logic [7:0] cmd_opcode, cmd_type, cmd_index, reply_status, reply_opcode, st_m, op_m;
  logic [31:0] cmd_value, reply_value, accu, xreg, var_m [256];
  logic [31:0] accu_m = 32'h0, x_m = 32'h0, seed = 32'h16;
  logic [2:0] fl_m = 3'h0;
  int n_errors = 0, n_compared = 0;
  always #25 clock = ~clock;
  issuer pm (.clock, .cmd_valid, .cmd_opcode, .cmd_type, .cmd_index, .cmd_value);
  accumulator_xreg_variable_calc uut (.clock, .arst_n, .cmd_valid, .cmd_opcode, .cmd_type,
    .cmd_index, .cmd_value, .xreg_load, .xreg_load_value, .reply_valid, .reply_status,
    .reply_opcode, .reply_value, .accu, .xreg, .flag_equal, .flag_greater, .flag_less);
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  function automatic logic [31:0] f(logic [3:0] t, logic [31:0] a, logic [31:0] b);
    logic signed [31:0] sa, sb, q, m;
    sa = a;
    sb = b;
    q = (sb == 0) ? sa : sa / sb;
    m = (sb == 0) ? sa : sa % sb;
    case (t)
      4'h0: return a + b;
      4'h1: return a - b;
      4'h2: return sa * sb;
      4'h3: return q;
      4'h4: return m;
      4'h5: return a & b;
      4'h6: return a | b;
      4'h7: return a ^ b;
      4'h8: return ~b;
      4'h9, 4'hA: return b;
      default: return a;
    endcase
  endfunction
  task automatic run(input logic [7:0] op, input logic [7:0] t, input logic [7:0] i);
    logic [31:0] a, b;
    logic av;
    pm.issue(op, t, i);
    av = (op == 8'h2A);
    op_m = op;
    a = av ? accu_m : var_m[i];
    b = av ? var_m[i] : x_m;
    st_m = (t > 8'h0B) ? calc_pkg::STATUS_BAD_TYPE : calc_pkg::STATUS_OK;
    if (!av && op != 8'h2B) st_m = calc_pkg::STATUS_BAD_OPC;
    if (st_m == calc_pkg::STATUS_OK) begin
      if (t == 8'h0B) fl_m = {a == b, $signed(a) > $signed(b), $signed(a) < $signed(b)};
      if (t == 8'h0A && av) var_m[i] = a;
      if (t == 8'h0A && !av) x_m = a;
      if (av) accu_m = f(t[3:0], a, b);
      else var_m[i] = f(t[3:0], a, b);
    end
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic settle();
    pm.quiet();
    #1;
    chk("accu", accu_m, accu);
    chk("xreg", x_m, xreg);
    chk("flags", {29'h0, fl_m}, {29'h0, flag_equal, flag_greater, flag_less});
    chk("reply", {15'h0, 1'b1, st_m, op_m}, {15'h0, reply_valid, reply_status, reply_opcode});
    chk("reply_value", calc_pkg::REPLY_VALUE, reply_value);
    @(posedge clock);
    #1;
    chk("reply_valid", 32'h0, {31'h0, reply_valid});
  endtask
  task automatic load_x(input logic [31:0] v);
    @(posedge clock);
    xreg_load <= 1'b1;
    xreg_load_value <= v;
    @(posedge clock);
    xreg_load <= 1'b0;
    x_m = v;
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    logic [31:0] r;
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    for (int k = 0; k < 256; k++) begin
      load_x((k == 0) ? 32'h0 : rnd());
      run(8'h2B, 8'h09, 8'(k));
      settle();
    end
    $display("test fill done");
    for (int t = 0; t < 12; t++) begin
      load_x(rnd());
      run(8'h2A, 8'(t), 8'(rnd()));
      settle();
      run(8'h2B, 8'(t), 8'(rnd()));
      settle();
    end
    load_x(32'h0);
    for (int t = 3; t < 5; t++) begin
      run(8'h2A, 8'(t), 8'h00);
      run(8'h2B, 8'(t), 8'h05);
      settle();
    end
    run(8'h2C, 8'h01, 8'h03);
    settle();
    run(8'h2A, 8'h0C, 8'h03);
    settle();
    run(8'h2B, 8'h1A, 8'h03);
    settle();
    $display("test corners done");
    for (int k = 0; k < 400; k++) begin
      r = rnd();
      if (r[30:29] == 2'h0) load_x(rnd());
      run(r[0] ? 8'h2A : 8'h2B, 8'(r[15:8] % 12), r[23:16]);
      if (r[31]) run(8'h2A, 8'h09, r[23:16]);
      settle();
    end
    $display("test random done");
    for (int k = 0; k < 256; k++) begin
      run(8'h2A, 8'h09, 8'(k));
      settle();
    end
    $display("test sweep done");
    give_verdict();
  end
endmodule // tb_top

/* verilog/accumulator_xreg_variable_calc.sv */
`timescale 1ns/1ps
module accumulator_xreg_variable_calc (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Instruction
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_opcode,
  input wire logic [7:0] cmd_type,
  input wire logic [7:0] cmd_index,
  input wire logic [31:0] cmd_value,
  // Register loads from other instructions
  input wire logic xreg_load,
  input wire logic [31:0] xreg_load_value,
  // Reply
  output logic reply_valid,
  output logic [7:0] reply_status,
  output logic [7:0] reply_opcode,
  output logic [31:0] reply_value,
  // State views
  output logic [31:0] accu,
  output logic [31:0] xreg,
  output logic flag_equal,
  output logic flag_greater,
  output logic flag_less
);
  typedef struct packed {
    logic [31:0] accu;
    logic [31:0] xreg;
    logic eq;
    logic gt;
    logic lt;
    logic rvalid;
    logic [7:0] rstatus;
    logic [7:0] ropc;
  } state_s;

  state_s state_reg, state_next;
  // Variables live in an array, no reset; software initialises them
  logic [31:0] vars [0:calc_pkg::VAR_COUNT-1];
  logic var_we;
  logic [31:0] var_wdata;
  logic [31:0] a, b, res, var_rd;
  logic sel_a, sel_x, type_ok, write_back;

  assign var_rd = vars[cmd_index];
  assign sel_a = cmd_valid && cmd_opcode == calc_pkg::OPC_ACCU_FROM_VAR;
  assign sel_x = cmd_valid && cmd_opcode == calc_pkg::OPC_VAR_FROM_XREG;
  assign type_ok = cmd_type <= 8'(calc_pkg::OP_COMP);

  always_comb begin
    state_next = state_reg;
    var_we = 1'b0;
    var_wdata = var_rd;
    a = sel_x ? var_rd : state_reg.accu;
    b = sel_x ? state_reg.xreg : var_rd;
    res = a;
    write_back = 1'b1;
    case (cmd_type[3:0])
      calc_pkg::OP_ADD: res = a + b;
      calc_pkg::OP_SUB: res = a - b;
      calc_pkg::OP_MUL: res = 32'($signed(a) * $signed(b));
      // Division by zero leaves the target unchanged
      calc_pkg::OP_DIV: res = (b == 32'h0) ? a : 32'($signed(a) / $signed(b));
      calc_pkg::OP_MOD: res = (b == 32'h0) ? a : 32'($signed(a) % $signed(b));
      calc_pkg::OP_AND: res = a & b;
      calc_pkg::OP_OR: res = a | b;
      calc_pkg::OP_XOR: res = a ^ b;
      calc_pkg::OP_NOT: res = ~b;
      calc_pkg::OP_LOAD: res = b;
      calc_pkg::OP_SWAP: res = b;
      default: write_back = 1'b0;
    endcase
    if (xreg_load) begin
      state_next.xreg = xreg_load_value;
    end
    state_next.rvalid = cmd_valid;
    state_next.ropc = cmd_opcode;
    if (!(sel_a || sel_x)) begin
      state_next.rstatus = calc_pkg::STATUS_BAD_OPC;
    end else if (!type_ok) begin
      state_next.rstatus = calc_pkg::STATUS_BAD_TYPE;
    end else begin
      state_next.rstatus = calc_pkg::STATUS_OK;
      if (sel_a && write_back) begin
        state_next.accu = res;
      end
      if (sel_x && write_back) begin
        var_we = 1'b1;
        var_wdata = res;
      end
      if (sel_a && cmd_type[3:0] == calc_pkg::OP_SWAP) begin
        var_we = 1'b1;
        var_wdata = state_reg.accu;
      end
      if (sel_x && cmd_type[3:0] == calc_pkg::OP_SWAP) begin
        state_next.xreg = var_rd;
      end
      if (cmd_type[3:0] == calc_pkg::OP_COMP) begin
        state_next.eq = a == b;
        state_next.gt = $signed(a) > $signed(b);
        state_next.lt = $signed(a) < $signed(b);
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= '{accu: calc_pkg::ACCU_RESET, xreg: calc_pkg::XREG_RESET,
                     rstatus: 8'h00, ropc: 8'h00, default: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clock) begin
    if (var_we) begin
      vars[cmd_index] <= var_wdata;
    end
  end

  assign reply_valid = state_reg.rvalid;
  assign reply_status = state_reg.rstatus;
  assign reply_opcode = state_reg.ropc;
  assign reply_value = calc_pkg::REPLY_VALUE;
  assign accu = state_reg.accu;
  assign xreg = state_reg.xreg;
  assign flag_equal = state_reg.eq;
  assign flag_greater = state_reg.gt;
  assign flag_less = state_reg.lt;

  property p_add_accu;
    @(posedge clock) disable iff (!arst_n)
      sel_a && cmd_type == 8'h00 |=> accu == $past(accu) + $past(var_rd);
  endproperty
  a_add_accu: assert property (p_add_accu) else $error("accu add wrong");

  property p_sub_accu;
    @(posedge clock) disable iff (!arst_n)
      sel_a && cmd_type == 8'h01 |=> accu == $past(accu) - $past(var_rd);
  endproperty
  a_sub_accu: assert property (p_sub_accu) else $error("accu sub wrong");

  property p_xor_accu;
    @(posedge clock) disable iff (!arst_n)
      sel_a && cmd_type == 8'h07 |=> accu == ($past(accu) ^ $past(var_rd));
  endproperty
  a_xor_accu: assert property (p_xor_accu) else $error("accu xor wrong");

  property p_not_accu;
    @(posedge clock) disable iff (!arst_n)
      sel_a && cmd_type == 8'h08 |=> accu == ~$past(var_rd);
  endproperty
  a_not_accu: assert property (p_not_accu) else $error("accu not wrong");

  property p_comp_keep;
    @(posedge clock) disable iff (!arst_n)
      sel_a && cmd_type == 8'h0B |=> $stable(accu);
  endproperty
  a_comp_keep: assert property (p_comp_keep) else $error("compare changed accu");

  property p_comp_flags;
    @(posedge clock) disable iff (!arst_n)
      (sel_a || sel_x) && cmd_type == 8'h0B
        |=> flag_equal == ($past(a) == $past(b)) && (flag_equal + flag_greater + flag_less == 1);
  endproperty
  a_comp_flags: assert property (p_comp_flags) else $error("compare flags wrong");

  property p_swap_x;
    @(posedge clock) disable iff (!arst_n)
      sel_x && cmd_type == 8'h0A && !xreg_load |=> xreg == $past(var_rd);
  endproperty
  a_swap_x: assert property (p_swap_x) else $error("x swap wrong");

  property p_var_add;
    @(posedge clock) disable iff (!arst_n)
      sel_x && cmd_type == 8'h00 |-> var_we && var_wdata == var_rd + state_reg.xreg;
  endproperty
  a_var_add: assert property (p_var_add) else $error("variable add wrong");

  property p_reply_ok;
    @(posedge clock) disable iff (!arst_n)
      (sel_a || sel_x) && type_ok |=> reply_valid && reply_status == calc_pkg::STATUS_OK;
  endproperty
  a_reply_ok: assert property (p_reply_ok) else $error("reply status wrong");

  property p_reply_pulse;
    @(posedge clock) disable iff (!arst_n)
      !cmd_valid |=> !reply_valid;
  endproperty
  a_reply_pulse: assert property (p_reply_pulse) else $error("reply not a pulse");

  property p_refuse_keep;
    @(posedge clock) disable iff (!arst_n)
      cmd_valid && !((sel_a || sel_x) && type_ok) && !xreg_load
        |=> $stable(accu) && $stable(xreg) && reply_status != calc_pkg::STATUS_OK;
  endproperty
  a_refuse_keep: assert property (p_refuse_keep) else $error("refused command acted");

  property p_swap_accu;
    @(posedge clock) disable iff (!arst_n)
      sel_a && cmd_type == 8'h0A |=> accu == $past(var_rd);
  endproperty
  a_swap_accu: assert property (p_swap_accu) else $error("accu swap wrong");

  property p_var_load;
    @(posedge clock) disable iff (!arst_n)
      sel_x && cmd_type == 8'h09 |-> var_we && var_wdata == state_reg.xreg;
  endproperty
  a_var_load: assert property (p_var_load) else $error("variable load wrong");

  property p_comp_greater;
    @(posedge clock) disable iff (!arst_n)
      (sel_a || sel_x) && cmd_type == 8'h0B
        |=> flag_greater == ($signed($past(a)) > $signed($past(b)));
  endproperty
  a_comp_greater: assert property (p_comp_greater) else $error("greater flag wrong");
endmodule // accumulator_xreg_variable_calc

/* verilog/calc_pkg.sv */
package calc_pkg;
  localparam int DATA_W = 32;
  localparam int INDEX_W = 8;
  localparam int VAR_COUNT = 256;
  localparam logic [7:0] OPC_ACCU_FROM_VAR = 8'h2A;
  localparam logic [7:0] OPC_VAR_FROM_XREG = 8'h2B;
  localparam logic [7:0] STATUS_OK = 8'h64;
  localparam logic [7:0] STATUS_BAD_TYPE = 8'h03;
  localparam logic [7:0] STATUS_BAD_OPC = 8'h02;
  localparam logic [31:0] ACCU_RESET = 32'h0000_0000;
  localparam logic [31:0] XREG_RESET = 32'h0000_0000;
  localparam logic [31:0] REPLY_VALUE = 32'h0000_0000;
  typedef enum logic [3:0] {
    OP_ADD, OP_SUB, OP_MUL, OP_DIV, OP_MOD, OP_AND, OP_OR, OP_XOR,
    OP_NOT, OP_LOAD, OP_SWAP, OP_COMP
  } calc_op_e;
endpackage
